//--- rtl/ailc_ctrl.sv
// Input current limit gate and automatic input limiting stepper.
// Assumes all inputs are synchronous to clk_in and the analog side compares VBUS against vbus_stop_threshold_out.
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
module ailc_ctrl #(
    parameter int unsigned DEB_LONG_CYC  = ailc_pkg::DEB_LONG_CYC,
    parameter int unsigned DEB_SHORT_CYC = ailc_pkg::DEB_SHORT_CYC,
    parameter int unsigned BLK0_CYC      = ailc_pkg::BLK0_CYC,
    parameter int unsigned BLK1_CYC      = ailc_pkg::BLK1_CYC,
    parameter int unsigned BLK2_CYC      = ailc_pkg::BLK2_CYC,
    parameter int unsigned BLK3_CYC      = ailc_pkg::BLK3_CYC,
    parameter int unsigned STEP0_CYC     = ailc_pkg::STEP0_CYC,
    parameter int unsigned STEP1_CYC     = ailc_pkg::STEP1_CYC,
    parameter int unsigned STEP2_CYC     = ailc_pkg::STEP2_CYC,
    parameter int unsigned STEP3_CYC     = ailc_pkg::STEP3_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       detect_running_in,
    input  wire logic [1:0] port_type_in,
    input  wire logic [2:0] proprietary_type_in,
    input  wire logic [6:0] requested_limit_code_in,
    input  wire logic       app_write_protect_in,
    input  wire logic       vbus_below_in,
    output logic      [2:0] vbus_stop_threshold_out,
    output logic      [6:0] input_current_limit_code_out,
    output logic            auto_limit_running_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] blank_cycles(input logic [1:0] sel);
        unique case (sel)
            2'h0: blank_cycles = 32'(BLK0_CYC);
            2'h1: blank_cycles = 32'(BLK1_CYC);
            2'h2: blank_cycles = 32'(BLK2_CYC);
            2'h3: blank_cycles = 32'(BLK3_CYC);
        endcase
    endfunction : blank_cycles

    function automatic logic [31:0] step_cycles(input logic [1:0] sel);
        unique case (sel)
            2'h0: step_cycles = 32'(STEP0_CYC);
            2'h1: step_cycles = 32'(STEP1_CYC);
            2'h2: step_cycles = 32'(STEP2_CYC);
            2'h3: step_cycles = 32'(STEP3_CYC);
        endcase
    endfunction : step_cycles

    // Ceiling code n is (n+1)*100mA; three limit codes make 100mA above code 3.
    function automatic logic [6:0] ceiling_code(input logic [4:0] c);
        ceiling_code = 7'(ailc_pkg::CODE_100MA + 7'(c) * 7'h03);
    endfunction : ceiling_code

    // ****************************************************************
    // State
    // ****************************************************************
    ailc_pkg::ailc_state_t st_q;
    ailc_pkg::ailc_state_t st_d;

    logic       gate;
    logic [1:0] std_cap;
    logic       chg_cap;
    logic       enable;
    logic       abort;
    logic [4:0] ceiling;
    logic [6:0] target;
    logic [6:0] ceil_code;
    logic       protect_hit;
    logic [31:0] deb_limit;

    assign gate      = st_q.ovr[ailc_pkg::GATE_BIT];
    assign std_cap   = st_q.ovr[ailc_pkg::STD_LSB +: 2];
    assign chg_cap   = st_q.ovr[ailc_pkg::CHG_BIT];
    assign enable    = st_q.run[ailc_pkg::EN_BIT];
    assign abort     = st_q.run[ailc_pkg::ABORT_BIT];
    assign ceiling   = st_q.thr[ailc_pkg::CEIL_LSB +: 5];
    assign ceil_code = ceiling_code(ceiling);
    assign deb_limit = st_q.tim[ailc_pkg::DEB_BIT] ? 32'(DEB_SHORT_CYC) : 32'(DEB_LONG_CYC);
    assign protect_hit = app_write_protect_in && reg_addr_in >= ailc_pkg::ADDR_RUN
                         && reg_addr_in <= ailc_pkg::ADDR_TIMING;

    // Cable overrides only act with the gate set, because only then has detection settled.
    always_comb begin
        target = requested_limit_code_in;
        if (gate && proprietary_type_in == ailc_pkg::PROP_NONE) begin
            if (port_type_in == ailc_pkg::PORT_STD) begin
                unique case (std_cap)
                    2'h0: target = requested_limit_code_in;
                    2'h1: target = ailc_pkg::CODE_500MA;
                    2'h2: target = ailc_pkg::CODE_1A;
                    2'h3: target = ailc_pkg::CODE_1A5;
                endcase
            end else if (port_type_in == ailc_pkg::PORT_CHG && chg_cap) begin
                target = ailc_pkg::CODE_1A5;
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        // Debounce in both directions so a single glitch neither stops nor restarts stepping.
        if (vbus_below_in == st_q.deb_uv) begin
            st_d.deb_cnt = 32'h0;
        end else if (st_q.deb_cnt + 32'h1 >= deb_limit) begin
            st_d.deb_cnt = 32'h0;
            st_d.deb_uv  = vbus_below_in;
        end else begin
            st_d.deb_cnt = st_q.deb_cnt + 32'h1;
        end
        if (!gate || !detect_running_in) begin
            st_d.applied = target;
        end
        unique case (st_q.phase)
            ailc_pkg::ST_IDLE: begin
                if (enable && !abort) begin
                    st_d.phase      = ailc_pkg::ST_BLANK;
                    st_d.timer      = blank_cycles(st_q.tim[ailc_pkg::BLK_LSB +: 2]) - 32'h1;
                    st_d.step_code  = st_q.auto_valid ? st_q.step_code : st_q.applied;
                    st_d.auto_valid = 1'b1;
                end
            end
            ailc_pkg::ST_BLANK: begin
                if (st_q.timer == 32'h0) begin
                    st_d.phase = ailc_pkg::ST_STEP;
                    st_d.timer = step_cycles(st_q.tim[ailc_pkg::STEP_LSB +: 2]) - 32'h1;
                end else begin
                    st_d.timer = st_q.timer - 32'h1;
                end
            end
            ailc_pkg::ST_STEP: begin
                if (st_q.deb_uv || st_q.step_code >= ceil_code) begin
                    st_d.phase = ailc_pkg::ST_IDLE;
                    st_d.run[ailc_pkg::EN_BIT] = 1'b0;
                end else if (st_q.timer == 32'h0) begin
                    st_d.step_code = st_q.step_code + 7'h01;
                    st_d.timer     = step_cycles(st_q.tim[ailc_pkg::STEP_LSB +: 2]) - 32'h1;
                end else begin
                    st_d.timer = st_q.timer - 32'h1;
                end
            end
        endcase
        if (abort) begin
            st_d.phase      = ailc_pkg::ST_IDLE;
            st_d.auto_valid = 1'b0;
            st_d.timer      = 32'h0;
        end
        // A software write lands after the hardware clear, so a fresh enable is never lost.
        if (reg_wr_in && !protect_hit) begin
            unique case (reg_addr_in)
                ailc_pkg::ADDR_OVERRIDE:  st_d.ovr = reg_wdata_in & ailc_pkg::MASK_OVERRIDE;
                ailc_pkg::ADDR_RUN:       st_d.run = reg_wdata_in & ailc_pkg::MASK_RUN;
                ailc_pkg::ADDR_THRESHOLD: st_d.thr = reg_wdata_in;
                ailc_pkg::ADDR_TIMING:    st_d.tim = reg_wdata_in & ailc_pkg::MASK_TIMING;
                default: ;
            endcase
        end
        st_d.rdata = 8'h00;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ailc_pkg::ADDR_LIMIT_CODE: st_d.rdata = {1'b0, input_current_limit_code_out};
                ailc_pkg::ADDR_OVERRIDE:   st_d.rdata = st_q.ovr;
                ailc_pkg::ADDR_RUN:        st_d.rdata = st_q.run;
                ailc_pkg::ADDR_THRESHOLD:  st_d.rdata = st_q.thr;
                ailc_pkg::ADDR_TIMING:     st_d.rdata = st_q.tim;
                default:                   st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q            <= '0;
            st_q.ovr        <= ailc_pkg::RESET_REG;
            st_q.run        <= ailc_pkg::RESET_REG;
            st_q.thr        <= ailc_pkg::RESET_REG;
            st_q.tim        <= ailc_pkg::RESET_REG;
            st_q.applied    <= ailc_pkg::CODE_100MA;
            st_q.step_code  <= ailc_pkg::CODE_100MA;
            st_q.phase      <= ailc_pkg::ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign reg_rdata_out                = st_q.rdata;
    assign vbus_stop_threshold_out      = st_q.thr[ailc_pkg::THR_LSB +: 3];
    assign input_current_limit_code_out = st_q.auto_valid ? st_q.step_code : st_q.applied;
    assign auto_limit_running_out       = st_q.phase != ailc_pkg::ST_IDLE;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence step_due;
        st_q.phase == ailc_pkg::ST_STEP && st_q.timer == 32'h0 && !st_q.deb_uv
            && st_q.step_code < ceil_code && !abort;
    endsequence

    sequence run_request;
        st_q.phase == ailc_pkg::ST_IDLE && enable && !abort;
    endsequence

    AST_NO_GATE_FOLLOWS: assert property (
        !gate |=> st_q.applied == $past(requested_limit_code_in))
        else $error("Ungated limit did not follow the request.");

    AST_GATE_HOLDS: assert property (
        gate && detect_running_in |=> $stable(st_q.applied))
        else $error("Gated limit changed while detection was running.");

    AST_STD_CAP_500MA: assert property (
        gate && !detect_running_in && std_cap == 2'h1 && port_type_in == ailc_pkg::PORT_STD
        && proprietary_type_in == ailc_pkg::PROP_NONE |=> st_q.applied == 7'h0f)
        else $error("Standard port cap did not force 500mA code.");

    AST_STD_CAP_1A5: assert property (
        gate && !detect_running_in && std_cap == 2'h3 && port_type_in == ailc_pkg::PORT_STD
        && proprietary_type_in == ailc_pkg::PROP_NONE |=> st_q.applied == 7'h2d)
        else $error("Standard port cap did not force 1.5A code.");

    AST_CHG_CAP: assert property (
        gate && !detect_running_in && chg_cap && port_type_in == ailc_pkg::PORT_CHG
        && proprietary_type_in == ailc_pkg::PROP_NONE |=> st_q.applied == 7'h2d)
        else $error("Charging port cap did not force 1.5A code.");

    AST_ABORT_STOPS: assert property (
        abort |=> !auto_limit_running_out && !st_q.auto_valid)
        else $error("Stepper ran while abort was set.");

    AST_PROTECT: assert property (
        reg_wr_in && app_write_protect_in && reg_addr_in == ailc_pkg::ADDR_THRESHOLD
        |=> $stable(st_q.thr))
        else $error("Protected threshold register accepted a write.");

    AST_START_BLANK: assert property (
        run_request |=> st_q.phase == ailc_pkg::ST_BLANK ##0 auto_limit_running_out)
        else $error("Run request did not start blanking.");

    AST_STEP_UP: assert property (
        step_due |=> input_current_limit_code_out == $past(input_current_limit_code_out) + 7'h01)
        else $error("Stepper did not raise the code by one.");

    AST_CEILING_STOP: assert property (
        st_q.phase == ailc_pkg::ST_STEP && st_q.step_code >= ceil_code && !abort
        && !(reg_wr_in && reg_addr_in == ailc_pkg::ADDR_RUN)
        |=> !auto_limit_running_out && !enable)
        else $error("Stepper passed the ceiling.");

    AST_READ_CODE: assert property (
        reg_rd_in && reg_addr_in == ailc_pkg::ADDR_LIMIT_CODE
        |=> reg_rdata_out == {1'b0, $past(input_current_limit_code_out)})
        else $error("Limit code read back wrong.");

    AST_STD_CAP_1A: assert property (
        gate && !detect_running_in && std_cap == 2'h2 && port_type_in == ailc_pkg::PORT_STD
        && proprietary_type_in == ailc_pkg::PROP_NONE |=> st_q.applied == 7'h1e)
        else $error("Standard port cap did not force 1A code.");

    AST_STD_CAP_NONE: assert property (
        gate && !detect_running_in && std_cap == 2'h0 && port_type_in == ailc_pkg::PORT_STD
        |=> st_q.applied == $past(requested_limit_code_in))
        else $error("Standard port cap 00 modified the limit code.");

    AST_CHG_CAP_OFF: assert property (
        gate && !detect_running_in && !chg_cap && port_type_in == ailc_pkg::PORT_CHG
        |=> st_q.applied == $past(requested_limit_code_in))
        else $error("Charging port cap off modified the limit code.");

    AST_THRESHOLD_OUT: assert property (
        reg_wr_in && !app_write_protect_in && reg_addr_in == ailc_pkg::ADDR_THRESHOLD
        |=> vbus_stop_threshold_out == $past(reg_wdata_in[ailc_pkg::THR_LSB +: 3]))
        else $error("Threshold select did not follow the written field.");

    AST_PROTECT_TIMING: assert property (
        reg_wr_in && app_write_protect_in && reg_addr_in == ailc_pkg::ADDR_TIMING
        |=> $stable(st_q.tim))
        else $error("Protected timing register accepted a write.");

    AST_PROTECT_RUN: assert property (
        reg_wr_in && app_write_protect_in && reg_addr_in == ailc_pkg::ADDR_RUN
        |=> abort == $past(abort))
        else $error("Protected run register accepted a write.");

    AST_DEBOUNCE_FIRST: assert property (
        st_q.deb_cnt == 32'h0 && vbus_below_in != st_q.deb_uv && deb_limit > 32'h1
        |=> $stable(st_q.deb_uv))
        else $error("Undervoltage flag changed on a single sample.");

endmodule : ailc_ctrl

//--- rtl/ailc_pkg.sv
// Constants, register map and state record for the input current limit controller.
// Assumes a 250 MHz clock and a byte-wide register port with printed offsets as addresses.
package ailc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_LIMIT_CODE = 8'h2a;
    localparam logic [7:0] ADDR_OVERRIDE   = 8'h2b;
    localparam logic [7:0] ADDR_RUN        = 8'h2c;
    localparam logic [7:0] ADDR_THRESHOLD  = 8'h2d;
    localparam logic [7:0] ADDR_TIMING     = 8'h2e;
    localparam logic [7:0] MASK_OVERRIDE   = 8'h0f;
    localparam logic [7:0] MASK_RUN        = 8'h81;
    localparam logic [7:0] MASK_TIMING     = 8'h1f;
    localparam logic [7:0] RESET_REG       = 8'h00;

    // Field positions.
    localparam int GATE_BIT  = 3;
    localparam int STD_LSB   = 1;
    localparam int CHG_BIT   = 0;
    localparam int EN_BIT    = 7;
    localparam int ABORT_BIT = 0;
    localparam int THR_LSB   = 5;
    localparam int CEIL_LSB  = 0;
    localparam int DEB_BIT   = 4;
    localparam int BLK_LSB   = 2;
    localparam int STEP_LSB  = 0;

    // Port type codes and forced limit codes.
    localparam logic [1:0] PORT_STD   = 2'h1;
    localparam logic [1:0] PORT_CHG   = 2'h2;
    localparam logic [2:0] PROP_NONE  = 3'h0;
    localparam logic [6:0] CODE_500MA = 7'h0f;
    localparam logic [6:0] CODE_1A    = 7'h1e;
    localparam logic [6:0] CODE_1A5   = 7'h2d;
    localparam logic [6:0] CODE_100MA = 7'h03;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEB_LONG_US   = 500;
    localparam int DEB_SHORT_US  = 200;
    localparam int BLK0_MS       = 500;
    localparam int BLK1_MS       = 1000;
    localparam int BLK2_MS       = 1500;
    localparam int BLK3_MS       = 5000;
    localparam int STEP0_MS      = 100;
    localparam int STEP1_MS      = 200;
    localparam int STEP2_MS      = 300;
    localparam int STEP3_MS      = 500;
    localparam int DEB_LONG_CYC  = DEB_LONG_US * 1000 / CLK_PERIOD_NS;
    localparam int DEB_SHORT_CYC = DEB_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int BLK0_CYC      = BLK0_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int BLK1_CYC      = BLK1_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int BLK2_CYC      = BLK2_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int BLK3_CYC      = BLK3_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int STEP0_CYC     = STEP0_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int STEP1_CYC     = STEP1_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int STEP2_CYC     = STEP2_MS * 1000 / CLK_PERIOD_NS * 1000;
    localparam int STEP3_CYC     = STEP3_MS * 1000 / CLK_PERIOD_NS * 1000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BLANK,
        ST_STEP
    } ailc_phase_t;

    typedef struct packed {
        logic [7:0]  ovr;
        logic [7:0]  run;
        logic [7:0]  thr;
        logic [7:0]  tim;
        logic [6:0]  applied;
        logic [6:0]  step_code;
        logic        auto_valid;
        ailc_phase_t phase;
        logic [31:0] timer;
        logic [31:0] deb_cnt;
        logic        deb_uv;
        logic [7:0]  rdata;
    } ailc_state_t;

endpackage : ailc_pkg

//--- verif/ailc_adapter_model.sv
// Behavioural model of the charging adapter feeding VBUS through its own current limit.
// Assumes the applied limit code stands for the drawn current and that the comparator trips one clock later.
`timescale 1ns/10ps
module ailc_adapter_model (
    input  wire logic       clk_in,
    input  wire logic [6:0] limit_code_in,
    input  wire logic [6:0] capacity_in,
    output logic            vbus_below_out
);
    // ****************************************************************
    // Sag model
    // ****************************************************************
    // A weak adapter collapses as soon as the draw passes its capability.
    // The sag is registered so the stepper never sees it in the same cycle it raises the code.
    initial vbus_below_out = 1'b0;
    always_ff @(posedge clk_in) begin
        vbus_below_out <= (limit_code_in > capacity_in);
    end
endmodule : ailc_adapter_model

//--- verif/ailc_ctrl_tb.sv
// Self-checking testbench for the input current limit controller.
// Assumes short timing parameters; the adapter model drives the VBUS comparator input.
`timescale 1ns/10ps
module ailc_ctrl_tb;
    localparam int BLK_C [4] = '{20, 24, 28, 40};
    localparam int STP_C [4] = '{10, 12, 14, 16};
    localparam int DEB_C [2] = '{8, 4};
    logic       clk_in, rst_n_in, reg_wr_in, reg_rd_in, detect_running_in, app_write_protect_in;
    logic [7:0] reg_addr_in, reg_wdata_in;
    logic [1:0] port_type_in;
    logic [2:0] proprietary_type_in;
    logic [6:0] requested_limit_code_in, capacity, c0;
    logic [7:0] rdata, sdp_exp [4];
    logic [2:0] thr;
    logic [6:0] code;
    logic       running, below;
    int         fails, compares, n;

    ailc_ctrl #(.DEB_LONG_CYC(DEB_C[0]), .DEB_SHORT_CYC(DEB_C[1]), .BLK0_CYC(BLK_C[0]), .BLK1_CYC(BLK_C[1]),
        .BLK2_CYC(BLK_C[2]), .BLK3_CYC(BLK_C[3]), .STEP0_CYC(STP_C[0]), .STEP1_CYC(STP_C[1]),
        .STEP2_CYC(STP_C[2]), .STEP3_CYC(STP_C[3])) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata),
        .detect_running_in(detect_running_in), .port_type_in(port_type_in),
        .proprietary_type_in(proprietary_type_in), .requested_limit_code_in(requested_limit_code_in),
        .app_write_protect_in(app_write_protect_in), .vbus_below_in(below),
        .vbus_stop_threshold_out(thr), .input_current_limit_code_out(code), .auto_limit_running_out(running));
    ailc_adapter_model PARTNER (.clk_in(clk_in), .limit_code_in(code), .capacity_in(capacity),
        .vbus_below_out(below));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        chk(rdata, exp, "register read");
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in);
    endtask : settle

    task automatic wait_idle(input int bound);
        n = 0;
        while (running !== 1'b0 && n < bound) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= bound) begin
            fails++;
            $display("BAD t=%0t stepper never stopped", $time);
            report_and_stop();
        end
    endtask : wait_idle

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {reg_wr_in, reg_rd_in, detect_running_in, app_write_protect_in} = 4'h0;
        reg_addr_in = 8'h00;
        reg_wdata_in = 8'h00;
        port_type_in = 2'h0;
        proprietary_type_in = 3'h0;
        requested_limit_code_in = 7'h03;
        capacity = 7'h7f;
        rst_n_in = 1'b0;
        fails = 0;
        compares = 0;
        sdp_exp = '{8'h50, 8'h0f, 8'h1e, 8'h2d};
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(ailc_pkg::ADDR_LIMIT_CODE, 8'h03);
        for (int a = 8'h2b; a <= 8'h2e; a++) rd(8'(a), 8'h00);
        rd(8'h40, 8'h00);
        wr(ailc_pkg::ADDR_OVERRIDE, 8'hff);
        rd(ailc_pkg::ADDR_OVERRIDE, 8'h0f);
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h00);
        wr(ailc_pkg::ADDR_LIMIT_CODE, 8'h55);
        rd(ailc_pkg::ADDR_LIMIT_CODE, 8'h03);
        @(posedge clk_in);
        detect_running_in <= 1'b1;
        requested_limit_code_in <= 7'h20;
        settle();
        chk({1'b0, code}, 8'h20, "ungated limit");
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h08);
        requested_limit_code_in <= 7'h50;
        settle();
        chk({1'b0, code}, 8'h20, "gated hold");
        @(posedge clk_in);
        detect_running_in <= 1'b0;
        settle();
        chk({1'b0, code}, 8'h50, "gated release");
        @(posedge clk_in);
        port_type_in <= ailc_pkg::PORT_STD;
        for (int s = 0; s < 4; s++) begin
            wr(ailc_pkg::ADDR_OVERRIDE, 8'(8 + 2 * s));
            settle();
            chk({1'b0, code}, sdp_exp[s], "standard cap");
        end
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h02);
        settle();
        chk({1'b0, code}, 8'h50, "cap without gate");
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h0a);
        proprietary_type_in <= 3'h1;
        settle();
        chk({1'b0, code}, 8'h50, "proprietary port");
        @(posedge clk_in);
        proprietary_type_in <= 3'h0;
        port_type_in <= ailc_pkg::PORT_CHG;
        settle();
        chk({1'b0, code}, 8'h50, "charging cap off");
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h09);
        settle();
        chk({1'b0, code}, 8'h2d, "charging cap");
        wr(ailc_pkg::ADDR_OVERRIDE, 8'h00);
        requested_limit_code_in <= 7'h03;
        app_write_protect_in <= 1'b1;
        for (int a = 8'h2c; a <= 8'h2e; a++) wr(8'(a), 8'hff);
        for (int a = 8'h2c; a <= 8'h2e; a++) rd(8'(a), 8'h00);
        @(posedge clk_in);
        app_write_protect_in <= 1'b0;
        wr(ailc_pkg::ADDR_THRESHOLD, 8'h5f);
        rd(ailc_pkg::ADDR_THRESHOLD, 8'h5f);
        chk({5'h00, thr}, 8'h02, "threshold out");
        // The weak adapter trips above code 6, so each run must end on code 7 with no ceiling help.
        for (int d = 0; d < 2; d++) begin
            capacity <= 7'h06;
            wr(ailc_pkg::ADDR_TIMING, 8'(16 * d));
            wr(ailc_pkg::ADDR_RUN, 8'h80);
            settle();
            chk({7'h00, running}, 8'h01, "run start");
            wait_idle(400);
            chk({1'b0, code}, 8'h07, "undervoltage stop");
            chk(8'(n), 8'(BLK_C[0] + 4 * STP_C[0] + 1 + DEB_C[d]), "debounce time");
            capacity <= 7'h7f;
            wr(ailc_pkg::ADDR_RUN, 8'h01);
        end
        for (int s = 0; s < 4; s++) begin
            wr(ailc_pkg::ADDR_TIMING, 8'(5 * s));
            wr(ailc_pkg::ADDR_RUN, 8'h80);
            @(negedge clk_in);
            c0 = code;
            n = 1;
            while (code === c0 && n < 200) begin
                @(negedge clk_in);
                n++;
            end
            chk(8'(n >= BLK_C[s] + STP_C[s] - 2 && n <= BLK_C[s] + STP_C[s] + 3), 8'h01, "first step");
            wr(ailc_pkg::ADDR_RUN, 8'h01);
            settle();
            chk({7'h00, running}, 8'h00, "abort mid run");
            chk({1'b0, code}, 8'h03, "abort restores gated code");
        end
        wr(ailc_pkg::ADDR_RUN, 8'h81);
        repeat (5) @(negedge clk_in);
        chk({7'h00, running}, 8'h00, "abort beats enable");
        wr(ailc_pkg::ADDR_THRESHOLD, 8'h43);
        wr(ailc_pkg::ADDR_RUN, 8'h80);
        settle();
        chk({7'h00, running}, 8'h01, "ceiling run start");
        wait_idle(800);
        chk({1'b0, code}, 8'h0c, "ceiling stop");
        rd(ailc_pkg::ADDR_RUN, 8'h00);
        report_and_stop();
    end
endmodule : ailc_ctrl_tb
